// *** hw/cvc_pkg.sv ***
// constants for the comparator and reference control block
package cvc_pkg;
   // ======================================================
   // register indices and byte addresses
   localparam logic [9:0] CMP_CTRL_IDX = 10'h019;
   localparam logic [9:0] VREF_CTRL_IDX = 10'h099;
   localparam logic [9:0] FLAG_IDX = 10'h00C;
   localparam logic [9:0] PORT_DIR_IDX = 10'h085;
   localparam logic [9:0] PORT_VAL_IDX = 10'h005;
   localparam logic [11:0] CMP_CTRL_ADDR = {CMP_CTRL_IDX, 2'b00};
   localparam logic [11:0] VREF_CTRL_ADDR = {VREF_CTRL_IDX, 2'b00};
   localparam logic [11:0] FLAG_ADDR = {FLAG_IDX, 2'b00};
   localparam logic [11:0] PORT_DIR_ADDR = {PORT_DIR_IDX, 2'b00};
   localparam logic [11:0] PORT_VAL_ADDR = {PORT_VAL_IDX, 2'b00};
   // ======================================================
   // field positions
   localparam int RESULT_BIT = 6;
   localparam int INVERT_BIT = 4;
   localparam int SWAP_BIT = 3;
   localparam int VPOWER_BIT = 7;
   localparam int VRANGE_BIT = 5;
   localparam int FLAG_BIT = 3;
   localparam int OUT_PIN_BIT = 2;
   localparam int PORT_W = 6;
   // ======================================================
   // reset values and writable masks
   localparam logic [7:0] CMP_CTRL_RST = 8'h00;
   localparam logic [7:0] VREF_CTRL_RST = 8'h00;
   localparam logic [7:0] CMP_CTRL_WMASK = 8'h1F;
   localparam logic [7:0] VREF_CTRL_WMASK = 8'hAF;
   localparam logic [5:0] PORT_DIR_RST = 6'h3F;
   // ======================================================
   // comparator modes
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [2:0] MODE_OUT = 3'h1;
   localparam logic [2:0] MODE_PINS = 3'h2;
   localparam logic [2:0] MODE_REF_OUT = 3'h3;
   localparam logic [2:0] MODE_REF = 3'h4;
   localparam logic [2:0] MODE_MUX_OUT = 3'h5;
   localparam logic [2:0] MODE_MUX = 3'h6;
   localparam logic [2:0] MODE_OFF = 3'h7;
endpackage : cvc_pkg

// *** hw/cvc_top.sv ***
// comparator and voltage reference control with apb registers
//
// Overview of operation
// - result high when positive input is higher
// - invert bit flips result polarity
// - swap picks negative input in mux modes
// - three bit mode field selects eight modes
// - reset clears both control registers
// - mode 111 and reference off save power
// - comparator and reference keep running asleep
// - comparator event wakes sleeping device
// - wake leaves control registers unchanged
// - output modes drive pin unsynchronized
// - port direction bit 2 clear enables pin
// - analog pins read zero on port
// - reference power bit powers reference
// - range bit selects low reference range
// - low range level is level over 24
// - high range is quarter plus level/32
// - four modes feed reference to comparator
// - unimplemented bits read zero, ignore writes
// - flag sets on result mismatch with latch
// - comparator control register access relatches result
// - flag at bit 3, software writes it
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module cvc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmp_raw,
   input wire logic [5:0] port_pins,
   input wire logic sleep_mode,
   output logic out_pin_2_o,
   output logic out_pin_2_oe,
   output logic cmp_enable,
   output logic vref_to_pos,
   output logic neg_from_pos_pin,
   output logic vref_power,
   output logic vref_range_low,
   output logic [3:0] vref_level,
   output logic cmp_change_flag,
   output logic wake_req
);
   // ======================================================
   // declarations
   logic [4:0] cmp_ctrl_q;
   logic [7:0] vref_ctrl_q;
   logic [5:0] port_dir_q;
   logic flag_q;
   logic latch_q;
   logic [2:0] sync_q;
   logic stable_q;
   logic [5:0] pin_s1_q;
   logic [5:0] pin_s2_q;
   logic [5:0] pin_s3_q;
   logic [5:0] pin_val_q;
   logic ready_q;
   logic slverr_q;
   logic [31:0] rdata_q;
   logic cmp_on_q;
   logic vref_sel_q;
   logic nsel_q;
   logic pin_oe_q;
   logic wake_q;
   logic [2:0] mode;
   logic cmp_on;
   logic out_mode;
   logic ref_mode;
   logic result;
   logic [5:0] analog_mask;
   logic setup;
   logic access;
   logic wr_en;
   logic mapped;
   logic cmp_touch;
   logic [31:0] rd_mux;

   assign mode = cmp_ctrl_q[2:0];
   assign setup = psel && !penable;
   assign access = psel && penable && ready_q;
   assign wr_en = access && pwrite && !slverr_q;
   assign cmp_touch = access && (paddr == cvc_pkg::CMP_CTRL_ADDR);

   // ======================================================
   // mode decode
   // eight mode decode
   always_comb begin
      cmp_on = 1'b1;
      out_mode = 1'b0;
      ref_mode = 1'b0;
      analog_mask = 6'h03;
      case (mode)
         cvc_pkg::MODE_RESET: begin
            cmp_on = 1'b0;
            analog_mask = 6'h07;
         end
         cvc_pkg::MODE_OUT: begin
            out_mode = 1'b1;
         end
         cvc_pkg::MODE_PINS: begin
            analog_mask = 6'h03;
         end
         cvc_pkg::MODE_REF_OUT: begin
            out_mode = 1'b1;
            ref_mode = 1'b1;
            analog_mask = 6'h02;
         end
         cvc_pkg::MODE_REF: begin
            ref_mode = 1'b1;
            analog_mask = 6'h02;
         end
         cvc_pkg::MODE_MUX_OUT: begin
            out_mode = 1'b1;
            ref_mode = 1'b1;
         end
         cvc_pkg::MODE_MUX: begin
            ref_mode = 1'b1;
         end
         cvc_pkg::MODE_OFF: begin
            cmp_on = 1'b0;
            analog_mask = 6'h00;
         end
         default: begin
            cmp_on = 1'b0;
         end
      endcase
   end

   // ======================================================
   // comparator result synchronizer
   // three flop synchronizer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_q <= 3'h0;
      end else begin
         sync_q <= {sync_q[1:0], cmp_raw};
      end
   end

   // change accepted once second and third stages agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stable_q <= 1'b0;
      end else if (sync_q[1] == sync_q[2]) begin
         stable_q <= sync_q[2];
      end
   end

   assign result = cmp_on_q && (stable_q ^ cmp_ctrl_q[cvc_pkg::INVERT_BIT]);

   // ======================================================
   // port pin synchronizers
   generate
      for (genvar i = 0; i < cvc_pkg::PORT_W; i++) begin : g_pin
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_s1_q[i] <= 1'b0;
               pin_s2_q[i] <= 1'b0;
               pin_s3_q[i] <= 1'b0;
               pin_val_q[i] <= 1'b0;
            end else begin
               pin_s1_q[i] <= port_pins[i];
               pin_s2_q[i] <= pin_s1_q[i];
               pin_s3_q[i] <= pin_s2_q[i];
               if (pin_s2_q[i] == pin_s3_q[i]) begin
                  pin_val_q[i] <= pin_s3_q[i];
               end
            end
         end
      end
   endgenerate

   // ======================================================
   // control registers
   // reset only by presetn; wake has no effect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_ctrl_q <= cvc_pkg::CMP_CTRL_RST[4:0];
      end else if (wr_en && paddr == cvc_pkg::CMP_CTRL_ADDR) begin
         cmp_ctrl_q <= pwdata[4:0] & cvc_pkg::CMP_CTRL_WMASK[4:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vref_ctrl_q <= cvc_pkg::VREF_CTRL_RST;
      end else if (wr_en && paddr == cvc_pkg::VREF_CTRL_ADDR) begin
         vref_ctrl_q <= pwdata[7:0] & cvc_pkg::VREF_CTRL_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_dir_q <= cvc_pkg::PORT_DIR_RST;
      end else if (wr_en && paddr == cvc_pkg::PORT_DIR_ADDR) begin
         port_dir_q <= pwdata[5:0];
      end
   end

   // ======================================================
   // change detection
   // relatch on any comparator control access, read or write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= 1'b0;
      end else if (cmp_touch) begin
         latch_q <= result;
      end
   end

   // mismatch set wins over software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (result != latch_q) begin
         flag_q <= 1'b1;
      end else if (wr_en && paddr == cvc_pkg::FLAG_ADDR) begin
         flag_q <= pwdata[cvc_pkg::FLAG_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= sleep_mode && cmp_on && flag_q;
      end
   end

   // ======================================================
   // analog routing controls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_on_q <= 1'b0;
         vref_sel_q <= 1'b0;
         nsel_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         cmp_on_q <= cmp_on;
         vref_sel_q <= ref_mode;
         nsel_q <= cmp_ctrl_q[cvc_pkg::SWAP_BIT] &&
                   (mode == cvc_pkg::MODE_MUX ||
                    mode == cvc_pkg::MODE_MUX_OUT);
         pin_oe_q <= out_mode && !port_dir_q[cvc_pkg::OUT_PIN_BIT];
      end
   end

   // pin driven straight from the comparator, unclocked
   assign out_pin_2_o = pin_oe_q &&
                        (cmp_raw ^ cmp_ctrl_q[cvc_pkg::INVERT_BIT]);
   assign out_pin_2_oe = pin_oe_q;
   assign cmp_enable = cmp_on_q;
   assign vref_to_pos = vref_sel_q;
   assign neg_from_pos_pin = nsel_q;
   assign vref_power = vref_ctrl_q[cvc_pkg::VPOWER_BIT];
   assign vref_range_low = vref_ctrl_q[cvc_pkg::VRANGE_BIT];
   assign vref_level = vref_ctrl_q[3:0];
   assign cmp_change_flag = flag_q;
   assign wake_req = wake_q;

   // ======================================================
   // apb read mux and slave
   always_comb begin
      rd_mux = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         cvc_pkg::CMP_CTRL_ADDR: begin
            rd_mux[4:0] = cmp_ctrl_q;
            rd_mux[cvc_pkg::RESULT_BIT] = result;
         end
         cvc_pkg::VREF_CTRL_ADDR: begin
            rd_mux[7:0] = vref_ctrl_q;
         end
         cvc_pkg::FLAG_ADDR: begin
            rd_mux[cvc_pkg::FLAG_BIT] = flag_q;
         end
         cvc_pkg::PORT_DIR_ADDR: begin
            rd_mux[5:0] = port_dir_q;
         end
         cvc_pkg::PORT_VAL_ADDR: begin
            rd_mux[5:0] = pin_val_q & ~analog_mask;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // one wait-free access cycle after each setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_q <= 1'b0;
         slverr_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else if (setup) begin
         ready_q <= 1'b1;
         slverr_q <= !mapped;
         rdata_q <= (pwrite || !mapped) ? 32'h0000_0000 : rd_mux;
      end else begin
         ready_q <= 1'b0;
         slverr_q <= 1'b0;
      end
   end

   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = slverr_q;

   // ======================================================
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence

   a_apb_ready_timing: assert property (
      s_setup |=> pready) else $error("pready not one cycle after setup");

   a_ctrl_unimpl_zero: assert property (
      (s_access and (!pwrite && paddr == cvc_pkg::CMP_CTRL_ADDR)) |->
      !prdata[7] && !prdata[5] && (vref_ctrl_q & 8'h50) == 8'h00)
      else $error("unimplemented bit set");

   a_flag_set_mismatch: assert property (
      (result != latch_q) |=> flag_q)
      else $error("mismatch did not set flag");

   a_relatch_on_touch: assert property (
      cmp_touch |=> latch_q == $past(result))
      else $error("result not relatched");

   a_swap_only_mux: assert property (
      nsel_q |-> $past(mode == 3'h5 || mode == 3'h6))
      else $error("swap active outside mux modes");

   a_off_mode_idle: assert property (
      (mode == 3'h7) [*2] |-> !cmp_enable && !result)
      else $error("comparator not off in mode 111");

   a_ref_modes: assert property (
      ##1 vref_to_pos == $past(mode >= 3'h3 && mode <= 3'h6))
      else $error("reference routing wrong");

   a_pin_enable: assert property (
      out_pin_2_oe |-> $past(!port_dir_q[2] &&
      (mode == 3'h1 || mode == 3'h3 || mode == 3'h5)))
      else $error("pin driven without output mode");

   a_invert_result: assert property (
      (cmp_on_q && $stable(stable_q) && $changed(cmp_ctrl_q[4]))
      |-> result != $past(result))
      else $error("inversion did not flip result");

   a_sleep_wake: assert property (
      (sleep_mode && cmp_on && flag_q) |=> wake_req)
      else $error("no wake on comparator event");

   a_vref_write: assert property (
      (s_access and (pwrite && paddr == cvc_pkg::VREF_CTRL_ADDR)) |=>
      vref_power == $past(pwdata[7]))
      else $error("reference power not written");
endmodule : cvc_top

// *** testbench/cvc_analog_model.sv ***
// analog side model: comparator inputs and port pin levels
`timescale 1ns/100ps
module cvc_analog_model (
   input wire logic [7:0] pos_lvl,
   input wire logic [7:0] neg_lvl,
   input wire logic [5:0] ext_pins,
   input wire logic out_pin_2_o,
   input wire logic out_pin_2_oe,
   output logic cmp_raw,
   output logic [5:0] port_pins
);
   assign cmp_raw = (pos_lvl > neg_lvl);
   // pin 2 follows the driver when enabled
   assign port_pins = {ext_pins[5:3],
      out_pin_2_oe ? out_pin_2_o : ext_pins[2], ext_pins[1:0]};
endmodule : cvc_analog_model

// *** testbench/tb.sv ***
// register level testbench for the comparator control block
`timescale 1ns/100ps
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, cmp_raw, sleep_mode = 0;
   logic [5:0] port_pins;
   logic [7:0] pos_lvl = 8'h10, neg_lvl = 8'h20;
   logic o2, oe2, c_en, v_pos, n_pos, v_pw, v_lo, flag, wake;
   logic [3:0] v_lvl;
   logic [31:0] r;
   logic e;
   int n_fail = 0, checks_done = 0;
   logic [5:0] pmask [8] = '{6'h38, 6'h3C, 6'h3C, 6'h3D, 6'h3D, 6'h3C,
      6'h3C, 6'h3F};
   cvc_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_raw(cmp_raw), .port_pins(port_pins), .sleep_mode(sleep_mode),
      .out_pin_2_o(o2), .out_pin_2_oe(oe2), .cmp_enable(c_en),
      .vref_to_pos(v_pos), .neg_from_pos_pin(n_pos), .vref_power(v_pw),
      .vref_range_low(v_lo), .vref_level(v_lvl),
      .cmp_change_flag(flag), .wake_req(wake));
   cvc_analog_model i_model (.pos_lvl(pos_lvl), .neg_lvl(neg_lvl),
      .ext_pins(6'h3F), .out_pin_2_o(o2), .out_pin_2_oe(oe2),
      .cmp_raw(cmp_raw), .port_pins(port_pins));
   initial begin
      forever #10 pclk = ~pclk;
   end
   task finish_test;
      if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // request held until pready is sampled high at a rising edge
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) chk("pready", 1, 0);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [7:0] d);
      apb(1, a, {24'h0, d});
   endtask : wr
   task rd(input logic [11:0] a, input logic [7:0] x, input string nm);
      apb(0, a, 32'h0);
      chk(nm, {24'h0, x}, r);
   endtask : rd
   task settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : settle
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      rd(cvc_pkg::CMP_CTRL_ADDR, 8'h00, "cmp_ctrl");
      rd(cvc_pkg::VREF_CTRL_ADDR, 8'h00, "vref_ctrl");
      rd(cvc_pkg::PORT_DIR_ADDR, 8'h3F, "port_dir");
      rd(cvc_pkg::FLAG_ADDR, 8'h00, "flag");
      wr(cvc_pkg::PORT_DIR_ADDR, 8'h3B);
      pos_lvl <= 8'h30;
      for (int m = 0; m < 8; m++) begin
         wr(cvc_pkg::CMP_CTRL_ADDR, 8'(m));
         settle(6);
         rd(cvc_pkg::CMP_CTRL_ADDR, 8'(m) | ((m > 0 && m < 7) ? 8'h40
            : 8'h00), "result");
         chk("cmp_enable", (m > 0 && m < 7), c_en);
         chk("vref_to_pos", (m > 2 && m < 7), v_pos);
         chk("pin_oe", (m == 1 || m == 3 || m == 5), oe2);
         rd(cvc_pkg::PORT_VAL_ADDR, {2'b00, pmask[m]}, "port_val");
      end
      wr(cvc_pkg::CMP_CTRL_ADDR, 8'h02);
      settle(6);
      rd(cvc_pkg::CMP_CTRL_ADDR, 8'h42, "latch");
      wr(cvc_pkg::FLAG_ADDR, 8'h00);
      rd(cvc_pkg::FLAG_ADDR, 8'h00, "flag_clr");
      sleep_mode <= 1;
      pos_lvl <= 8'h10;
      settle(6);
      rd(cvc_pkg::FLAG_ADDR, 8'h08, "flag_set");
      chk("wake_req", 1, wake);
      chk("flag_out", 1, flag);
      sleep_mode <= 0;
      rd(cvc_pkg::CMP_CTRL_ADDR, 8'h02, "after_wake");
      wr(cvc_pkg::FLAG_ADDR, 8'h00);
      rd(cvc_pkg::FLAG_ADDR, 8'h00, "flag_end");
      wr(cvc_pkg::FLAG_ADDR, 8'h08);
      rd(cvc_pkg::FLAG_ADDR, 8'h08, "flag_sw");
      wr(cvc_pkg::FLAG_ADDR, 8'h00);
      wr(cvc_pkg::CMP_CTRL_ADDR, 8'h12);
      settle(6);
      rd(cvc_pkg::CMP_CTRL_ADDR, 8'h52, "inverted");
      wr(cvc_pkg::CMP_CTRL_ADDR, 8'h0E);
      settle(2);
      chk("swap_mux", 1, n_pos);
      wr(cvc_pkg::CMP_CTRL_ADDR, 8'h0A);
      settle(2);
      chk("swap_plain", 0, n_pos);
      wr(cvc_pkg::CMP_CTRL_ADDR, 8'h01);
      settle(2);
      chk("pin_before", 0, o2);
      @(posedge pclk);
      pos_lvl <= 8'h30;
      @(negedge pclk);
      chk("pin_direct", 1, o2);
      wr(cvc_pkg::PORT_DIR_ADDR, 8'h3F);
      settle(2);
      chk("pin_off", 0, oe2);
      wr(cvc_pkg::VREF_CTRL_ADDR, 8'hFF);
      rd(cvc_pkg::VREF_CTRL_ADDR, 8'hAF, "vref_all");
      settle(1);
      chk("vref_on", 6'h3F, {v_pw, v_lo, v_lvl});
      wr(cvc_pkg::VREF_CTRL_ADDR, 8'h0A);
      settle(1);
      chk("vref_high", 6'h0A, {v_pw, v_lo, v_lvl});
      wr(cvc_pkg::CMP_CTRL_ADDR, 8'hFF);
      rd(cvc_pkg::CMP_CTRL_ADDR, 8'h1F, "cmp_all");
      apb(0, 12'h100, 32'h0);
      chk("slverr", 1, e);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      rd(cvc_pkg::CMP_CTRL_ADDR, 8'h00, "cmp_rst2");
      rd(cvc_pkg::VREF_CTRL_ADDR, 8'h00, "vref_rst2");
      finish_test();
   end
endmodule : tb
